// ===== design/rtcsr_defs.vh
// Register offsets, field positions and timing constants of the clock register front end.
// Included by the counter and top design files of the block; holds definitions only.
`ifndef RTCSR_DEFS_VH
`define RTCSR_DEFS_VH
`define RTCSR_ADDR_W        13
`define RTCSR_FLAGS_ADDR    13'h1FF0
`define RTCSR_SPARE_ADDR    13'h1FF1
`define RTCSR_ALSEC_ADDR    13'h1FF2
`define RTCSR_ALMIN_ADDR    13'h1FF3
`define RTCSR_ALHR_ADDR     13'h1FF4
`define RTCSR_ALDATE_ADDR   13'h1FF5
`define RTCSR_IRQEN_ADDR    13'h1FF6
`define RTCSR_WDOG_ADDR     13'h1FF7
`define RTCSR_CTRL_ADDR     13'h1FF8
`define RTCSR_SEC_ADDR      13'h1FF9
`define RTCSR_MIN_ADDR      13'h1FFA
`define RTCSR_HR_ADDR       13'h1FFB
`define RTCSR_CENDAY_ADDR   13'h1FFC
`define RTCSR_DATE_ADDR     13'h1FFD
`define RTCSR_MONTH_ADDR    13'h1FFE
`define RTCSR_YEAR_ADDR     13'h1FFF
`define RTCSR_CTRL_LOAD_BIT 7
`define RTCSR_CTRL_HOLD_BIT 6
`define RTCSR_HALT_BIT      7
`define RTCSR_FTEST_BIT     6
`define RTCSR_CENT_EN_BIT   5
`define RTCSR_CENT_BIT      4
`define RTCSR_FLAG_TO_BIT   7
`define RTCSR_FLAG_AL_BIT   6
`define RTCSR_FLAG_BL_BIT   4
`define RTCSR_SEC_MASK      8'h7F
`define RTCSR_MIN_MASK      8'h7F
`define RTCSR_HR_MASK       8'h3F
`define RTCSR_CENDAY_MASK   8'h77
`define RTCSR_DATE_MASK     8'h3F
`define RTCSR_MONTH_MASK    8'h1F
`define RTCSR_IRQEN_MASK    8'hA0
`define RTCSR_CLK_HZ        200000000
`define RTCSR_TICK_HZ       1
`define RTCSR_REC_MIN_MS    40
`define RTCSR_REC_MAX_MS    200
`define RTCSR_REC_IND_MS    20
`define RTCSR_REC_CYCLES    ((`RTCSR_REC_MIN_MS * (`RTCSR_CLK_HZ / 1000)))
`define RTCSR_SEC_CYCLES    (`RTCSR_CLK_HZ / `RTCSR_TICK_HZ)
`endif

// ===== design/rtcsr_mem.v
// Byte-wide user memory below the clock registers, with registered read data.
// Assumes the caller gates writes during power-fail deselect.
`timescale 1ns/10ps
module rtcsr_mem #(
	parameter AW = 13,
	parameter DW = 8
) (
	input  wire          core_clk_in,
	input  wire          we_in,
	input  wire [AW-1:0] addr_in,
	input  wire [DW-1:0] wdata_in,
	output reg  [DW-1:0] rdata_out
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	always @(posedge core_clk_in)
	begin
		if (we_in)
		begin
			mem[addr_in] <= wdata_in;
		end
		rdata_out <= mem[addr_in];
	end
endmodule

// ===== design/rtcsr_counter.v
// Running BCD time counters with load port, one-second tick and oscillator halt.
// Assumes a one-cycle load pulse and BCD values within range.
`timescale 1ns/10ps
`include "rtcsr_defs.vh"
module rtcsr_counter #(
	parameter SEC_CYCLES = `RTCSR_SEC_CYCLES
) (
	input  wire        core_clk_in,
	input  wire        rstn_in,
	input  wire        halt_in,
	input  wire        load_in,
	input  wire [55:0] load_val_in,
	output reg  [55:0] time_out,
	output reg         tick_out
);
	reg [31:0] div;
	// The halt bit rides in bit 7 of the seconds byte and takes no part in counting.
	wire [7:0] s = {1'b0, time_out[6:0]};
	wire [7:0] mi = time_out[15:8];
	wire [7:0] h = time_out[23:16];
	wire [7:0] dw = time_out[31:24];
	wire [7:0] dt = time_out[39:32];
	wire [7:0] mo = time_out[47:40];
	wire [7:0] y = time_out[55:48];
	function [7:0] bcd_inc;
		input [7:0] v;
		begin
			if (v[3:0] == 4'h9)
				bcd_inc = {v[7:4] + 4'h1, 4'h0};
			else
				bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction
	always @(posedge core_clk_in)
	begin
		tick_out <= 1'b0;
		if (!rstn_in)
		begin
			div <= 32'h0;
			time_out <= {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
		end
		else if (load_in)
		begin
			div <= 32'h0;
			time_out <= load_val_in;
		end
		else if (!halt_in)
		begin
			if (div == SEC_CYCLES - 1)
			begin
				div <= 32'h0;
				tick_out <= 1'b1;
				time_out[7:0] <= (s == 8'h59) ? 8'h00 : bcd_inc(s);
				if (s == 8'h59)
				begin
					time_out[15:8] <= (mi == 8'h59) ? 8'h00 : bcd_inc(mi);
					if (mi == 8'h59)
					begin
						time_out[23:16] <= (h == 8'h23) ? 8'h00 : bcd_inc(h);
						if (h == 8'h23)
						begin
							time_out[26:24] <= (dw[2:0] == 3'h7) ? 3'h1 : dw[2:0] + 3'h1;
							time_out[39:32] <= (dt == 8'h31) ? 8'h01 : bcd_inc(dt);
							if (dt == 8'h31)
							begin
								time_out[47:40] <= (mo == 8'h12) ? 8'h01 : bcd_inc(mo);
								if (mo == 8'h12)
								begin
									time_out[55:48] <= (y == 8'h99) ? 8'h00 : bcd_inc(y);
									if (y == 8'h99 && dw[5])
										time_out[28] <= ~dw[4];
								end
							end
						end
					end
				end
			end
			else
			begin
				div <= div + 32'h1;
			end
		end
	end
endmodule

// ===== design/rtcsr_top.v
// Clock register front end: SRAM-style bus, power-fail deselect, hold, load and halt control.
// Assumes bus inputs already synchronous to core_clk_in and a power-good level from a comparator.
//
// How it works
// - Power fail blocks writes, floats bus.
// - Recovery keeps deselect and reset low.
// - Hold bit freezes visible time registers.
// - Frozen registers show time at hold.
// - Counters keep running while frozen.
// - All registers copy together; hold waits.
// - After hold clears, refresh within second.
// - Load bit halts refreshes for writing.
// - Clearing load bit loads the counters.
// - Next refresh within a second after load.
// - Power-up clears hold and load bits.
// - Halt bit in seconds stops oscillator.
// - Clearing halt restarts within one second.
// - Test, halt, century enable written directly.
// - Time values are 24-hour BCD.
// - Century/day register field layout.
// - Watchdog register field layout.
// - Interrupt enable register, two bits.
// - Alarm registers with repeat mask bits.
// - Flags register read-only, others zero.
// - Thirteen-bit address, select and strobe.
// - Control holds calibration and sign.
`timescale 1ns/10ps
`include "rtcsr_defs.vh"
module rtcsr_top #(
	parameter REC_CYCLES = `RTCSR_REC_CYCLES,
	parameter SEC_CYCLES = `RTCSR_SEC_CYCLES
) (
	input  wire        core_clk_in,
	input  wire        rstn_in,
	input  wire        power_good_in,
	input  wire        chip_sel_n_in,
	input  wire        out_en_n_in,
	input  wire        write_n_in,
	input  wire [12:0] addr_in,
	input  wire [7:0]  data_in,
	input  wire        timeout_flag_in,
	input  wire        alarm_hit_flag_in,
	input  wire        battery_low_flag_in,
	output reg  [7:0]  data_out,
	output wire        data_oe_out,
	output wire        cpu_reset_n_out
);
	localparam ST_OFF = 3'b001;
	localparam ST_REC = 3'b010;
	localparam ST_ON  = 3'b100;
	reg [2:0]  state;
	reg [31:0] rec_cnt;
	reg [7:0]  spare_byte;
	reg [7:0]  alarm_seconds;
	reg [7:0]  alarm_minutes;
	reg [7:0]  alarm_hours;
	reg [7:0]  alarm_day_of_month;
	reg [7:0]  interrupt_enables;
	reg [7:0]  watchdog_setup;
	reg [7:0]  control_and_calibration;
	reg [55:0] shown;
	reg        refresh_pend;
	reg        load_pulse;
	reg        wr_prev;
	reg        rd_sel;
	reg [7:0]  reg_rdata;
	wire [55:0] count_val;
	wire        tick;
	wire [7:0]  mem_rdata;
	wire        active = (state == ST_ON);
	wire        wr_now = active && !chip_sel_n_in && !write_n_in;
	wire        wr_stb = wr_now && !wr_prev;
	wire        is_reg = (addr_in[12:4] == 9'h1FF);
	wire        frozen = control_and_calibration[`RTCSR_CTRL_HOLD_BIT] | control_and_calibration[`RTCSR_CTRL_LOAD_BIT];
	wire        load_clear = wr_stb && addr_in == `RTCSR_CTRL_ADDR
		&& control_and_calibration[`RTCSR_CTRL_LOAD_BIT] && !data_in[`RTCSR_CTRL_LOAD_BIT];
	wire        osc_halt = shown[`RTCSR_HALT_BIT];
	function [7:0] time_byte;
		input [2:0]  idx;
		input [55:0] v;
		begin
			time_byte = v[idx*8 +: 8];
		end
	endfunction
	function [7:0] write_mask;
		input [12:0] a;
		begin
			case (a)
				`RTCSR_SEC_ADDR:    write_mask = 8'hFF;
				`RTCSR_MIN_ADDR:    write_mask = `RTCSR_MIN_MASK;
				`RTCSR_HR_ADDR:     write_mask = `RTCSR_HR_MASK;
				`RTCSR_CENDAY_ADDR: write_mask = `RTCSR_CENDAY_MASK;
				`RTCSR_DATE_ADDR:   write_mask = `RTCSR_DATE_MASK;
				`RTCSR_MONTH_ADDR:  write_mask = `RTCSR_MONTH_MASK;
				default:            write_mask = 8'hFF;
			endcase
		end
	endfunction
	rtcsr_counter #(
		.SEC_CYCLES(SEC_CYCLES)
	) u_counter (
		.core_clk_in (core_clk_in),
		.rstn_in     (rstn_in),
		.halt_in     (osc_halt),
		.load_in     (load_pulse),
		.load_val_in (shown),
		.time_out    (count_val),
		.tick_out    (tick)
	);
	rtcsr_mem #(
		.AW(13),
		.DW(8)
	) u_mem (
		.core_clk_in (core_clk_in),
		.we_in       (wr_stb && !is_reg),
		.addr_in     (addr_in),
		.wdata_in    (data_in),
		.rdata_out   (mem_rdata)
	);
	always @(posedge core_clk_in)
	begin
		if (!rstn_in)
		begin
			state <= ST_OFF;
			rec_cnt <= 32'h0;
		end
		else
		begin
			case (state)
				ST_OFF:
				begin
					rec_cnt <= 32'h0;
					if (power_good_in)
						state <= ST_REC;
				end
				ST_REC:
				begin
					if (!power_good_in)
						state <= ST_OFF;
					else if (rec_cnt == REC_CYCLES - 1)
						state <= ST_ON;
					else
						rec_cnt <= rec_cnt + 32'h1;
				end
				ST_ON:
				begin
					if (!power_good_in)
						state <= ST_OFF;
				end
				default:
				begin
					state <= ST_OFF;
				end
			endcase
		end
	end
	assign cpu_reset_n_out = active;
	assign data_oe_out = active && rd_sel;
	always @(posedge core_clk_in)
	begin
		if (!rstn_in)
		begin
			wr_prev <= 1'b0;
			rd_sel <= 1'b0;
			data_out <= 8'h00;
			load_pulse <= 1'b0;
			refresh_pend <= 1'b1;
			spare_byte <= 8'h00;
			alarm_seconds <= 8'h00;
			alarm_minutes <= 8'h00;
			alarm_hours <= 8'h00;
			alarm_day_of_month <= 8'h00;
			interrupt_enables <= 8'h00;
			watchdog_setup <= 8'h00;
			control_and_calibration <= 8'h00;
			shown <= 56'h0;
		end
		else
		begin
			wr_prev <= wr_now;
			rd_sel <= active && !chip_sel_n_in && write_n_in && !out_en_n_in;
			data_out <= is_reg ? reg_rdata : mem_rdata;
			load_pulse <= load_clear;
			if (!active)
			begin
				control_and_calibration[7:6] <= 2'b00;
				refresh_pend <= 1'b1;
			end
			if (tick || load_pulse)
				refresh_pend <= 1'b1;
			if (!frozen && (refresh_pend || tick) && !load_pulse)
			begin
				// Test and century enable bits are written directly, so a refresh keeps them.
				shown[55:32] <= count_val[55:32];
				shown[28:8] <= count_val[28:8];
				shown[6:0] <= count_val[6:0];
				refresh_pend <= 1'b0;
			end
			if (wr_stb && is_reg)
			begin
				case (addr_in)
					`RTCSR_SPARE_ADDR:  spare_byte <= data_in;
					`RTCSR_ALSEC_ADDR:  alarm_seconds <= data_in;
					`RTCSR_ALMIN_ADDR:  alarm_minutes <= data_in;
					`RTCSR_ALHR_ADDR:   alarm_hours <= data_in;
					`RTCSR_ALDATE_ADDR: alarm_day_of_month <= data_in;
					`RTCSR_IRQEN_ADDR:  interrupt_enables <= data_in & `RTCSR_IRQEN_MASK;
					`RTCSR_WDOG_ADDR:   watchdog_setup <= data_in;
					`RTCSR_CTRL_ADDR:   control_and_calibration <= data_in;
					`RTCSR_SEC_ADDR:
					begin
						shown[`RTCSR_HALT_BIT] <= data_in[`RTCSR_HALT_BIT];
						if (control_and_calibration[`RTCSR_CTRL_LOAD_BIT])
							shown[6:0] <= data_in[6:0];
					end
					`RTCSR_CENDAY_ADDR:
					begin
						shown[31:29] <= data_in[7:5];
						if (control_and_calibration[`RTCSR_CTRL_LOAD_BIT])
							shown[28:24] <= data_in[4:0] & 5'h17;
					end
					default:
					begin
						if (control_and_calibration[`RTCSR_CTRL_LOAD_BIT] && addr_in >= `RTCSR_MIN_ADDR)
							shown[(addr_in[2:0]-3'h1)*8 +: 8] <= data_in & write_mask(addr_in);
					end
				endcase
			end
			if (wr_stb && addr_in == `RTCSR_CENDAY_ADDR)
				shown[30] <= data_in[`RTCSR_FTEST_BIT];
		end
	end
	always @*
	begin
		reg_rdata = 8'h00;
		case (addr_in)
			`RTCSR_FLAGS_ADDR:
				reg_rdata = {timeout_flag_in, alarm_hit_flag_in, 1'b0, battery_low_flag_in, 4'h0};
			`RTCSR_SPARE_ADDR:  reg_rdata = spare_byte;
			`RTCSR_ALSEC_ADDR:  reg_rdata = alarm_seconds;
			`RTCSR_ALMIN_ADDR:  reg_rdata = alarm_minutes;
			`RTCSR_ALHR_ADDR:   reg_rdata = alarm_hours;
			`RTCSR_ALDATE_ADDR: reg_rdata = alarm_day_of_month;
			`RTCSR_IRQEN_ADDR:  reg_rdata = interrupt_enables;
			`RTCSR_WDOG_ADDR:   reg_rdata = watchdog_setup;
			`RTCSR_CTRL_ADDR:   reg_rdata = control_and_calibration;
			default:            reg_rdata = time_byte(addr_in[2:0] - 3'h1, shown);
		endcase
	end
endmodule

// ===== verif/rtcsr_checker.sv
// Concurrent checks on the ports of the clock register front end.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module rtcsr_checker #(
	parameter REC_CYCLES = 20
) (
	input wire        core_clk_in,
	input wire        rstn_in,
	input wire        power_good_in,
	input wire        chip_sel_n_in,
	input wire        out_en_n_in,
	input wire        write_n_in,
	input wire [12:0] addr_in,
	input wire [7:0]  data_in,
	input wire        timeout_flag_in,
	input wire        alarm_hit_flag_in,
	input wire        battery_low_flag_in,
	input wire [7:0]  data_out,
	input wire        data_oe_out,
	input wire        cpu_reset_n_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);
	integer good_cnt;
	wire    rd = !chip_sel_n_in && write_n_in && !out_en_n_in && power_good_in && cpu_reset_n_out;
	// Counts cycles of valid supply since reset or the last power failure.
	always @(posedge core_clk_in)
	begin
		if (!rstn_in || !power_good_in)
			good_cnt <= 0;
		else if (good_cnt < REC_CYCLES + 8)
			good_cnt <= good_cnt + 1;
	end
	property p_pf_float;
		!power_good_in |=> !data_oe_out;
	endproperty
	a_pf_float: assert property (p_pf_float) else $error("bus driven in power fail");
	property p_pf_reset;
		!power_good_in |=> !cpu_reset_n_out;
	endproperty
	a_pf_reset: assert property (p_pf_reset) else $error("reset out high in power fail");
	property p_rec_min;
		$rose(cpu_reset_n_out) |-> good_cnt >= REC_CYCLES - 1;
	endproperty
	a_rec_min: assert property (p_rec_min) else $error("recovery too short");
	property p_rec_max;
		good_cnt >= REC_CYCLES + 3 |-> cpu_reset_n_out;
	endproperty
	a_rec_max: assert property (p_rec_max) else $error("recovery too long");
	property p_read_oe;
		rd |=> data_oe_out;
	endproperty
	a_read_oe: assert property (p_read_oe) else $error("read not driven");
	property p_desel;
		chip_sel_n_in |=> !data_oe_out;
	endproperty
	a_desel: assert property (p_desel) else $error("driven while deselected");
	property p_wr_float;
		!write_n_in |=> !data_oe_out;
	endproperty
	a_wr_float: assert property (p_wr_float) else $error("driven during write");
	property p_flags;
		rd && addr_in == 13'h1FF0 |=> data_out[7] == $past(timeout_flag_in) && data_out[6] == $past(alarm_hit_flag_in)
			&& data_out[4] == $past(battery_low_flag_in) && data_out[5] == 1'b0 && data_out[3:0] == 4'h0;
	endproperty
	a_flags: assert property (p_flags) else $error("flags byte wrong");
	c_rec: cover property ($rose(cpu_reset_n_out));
	c_flags: cover property (rd && addr_in == 13'h1FF0);
	c_pf_sel: cover property (!power_good_in && !chip_sel_n_in);
endmodule
bind rtcsr_top rtcsr_checker #(.REC_CYCLES(REC_CYCLES)) u_chk (.core_clk_in, .rstn_in, .power_good_in,
	.chip_sel_n_in, .out_en_n_in, .write_n_in, .addr_in, .data_in, .timeout_flag_in, .alarm_hit_flag_in,
	.battery_low_flag_in, .data_out, .data_oe_out, .cpu_reset_n_out);

// ===== verif/rtcsr_host.sv
// Host processor model on the byte-wide SRAM-style bus.
// Assumes the device samples the bus on the rising clock edge.
`timescale 1ns/10ps
module rtcsr_host (
	input  wire        core_clk_in,
	input  wire [7:0]  rdata_in,
	output reg         cs_n_out,
	output reg         oe_n_out,
	output reg         we_n_out,
	output reg  [12:0] addr_out,
	output reg  [7:0]  data_out
);
	initial
	begin
		cs_n_out = 1'b1;
		oe_n_out = 1'b1;
		we_n_out = 1'b1;
		addr_out = 13'h0000;
		data_out = 8'h00;
	end
	// Fixed-zero bits are passed as given; some callers write them as ones to check the device masks.
	task wr(input [12:0] a, input [7:0] d);
	begin
		@(posedge core_clk_in);
		#1;
		cs_n_out = 1'b0;
		we_n_out = 1'b0;
		addr_out = a;
		data_out = d;
		@(posedge core_clk_in);
		#1;
		cs_n_out = 1'b1;
		we_n_out = 1'b1;
		data_out = ~d;
	end
	endtask
	task rd(input [12:0] a, output [7:0] d);
	begin
		@(posedge core_clk_in);
		#1;
		cs_n_out = 1'b0;
		oe_n_out = 1'b0;
		addr_out = a;
		repeat (2) @(posedge core_clk_in);
		#1;
		d = rdata_in;
		cs_n_out = 1'b1;
		oe_n_out = 1'b1;
	end
	endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the clock register front end.
// Assumes shortened recovery and one-second counts.
`timescale 1ns/10ps
module testbench;
	localparam REC = 20;
	localparam SEC = 50;
	localparam [55:0] LOADED = 56'hD9592307311299;
	localparam [55:0] ROLLED = 56'h00000001010100;
	reg core_clk_in = 1'b0;
	reg rstn_in = 1'b0;
	reg power_good_in = 1'b1;
	reg timeout_flag_in = 1'b1;
	reg alarm_hit_flag_in = 1'b0;
	reg battery_low_flag_in = 1'b1;
	wire chip_sel_n_in, out_en_n_in, write_n_in, data_oe_out, cpu_reset_n_out;
	wire [12:0] addr_in;
	wire [7:0] data_in, data_out;
	integer miscompares = 0;
	integer check_count = 0;
	integer i, n;
	reg [7:0] v, s0;
	reg [28:0] tab [0:11];
	always #2.5 core_clk_in = ~core_clk_in;
	rtcsr_top #(.REC_CYCLES(REC), .SEC_CYCLES(SEC)) dut (.core_clk_in, .rstn_in, .power_good_in,
		.chip_sel_n_in, .out_en_n_in, .write_n_in, .addr_in, .data_in, .timeout_flag_in, .alarm_hit_flag_in,
		.battery_low_flag_in, .data_out, .data_oe_out, .cpu_reset_n_out);
	rtcsr_host host (.core_clk_in, .rdata_in(data_out), .cs_n_out(chip_sel_n_in), .oe_n_out(out_en_n_in),
		.we_n_out(write_n_in), .addr_out(addr_in), .data_out(data_in));
	task chk(input [7:0] seen, input [7:0] exp, input [12:0] what);
	begin
		check_count = check_count + 1;
		if (seen !== exp)
		begin
			miscompares = miscompares + 1;
			$display("[ERR] %h expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	task print_verdict;
	begin
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	task wait_up;
	begin
		n = 0;
		while (cpu_reset_n_out !== 1'b1 && n < 4 * REC)
		begin
			@(posedge core_clk_in);
			#1;
			n = n + 1;
		end
		chk(cpu_reset_n_out, 1'b1, 13'h0000);
		if (cpu_reset_n_out !== 1'b1)
			print_verdict;
	end
	endtask
	initial
	begin
		tab[0] = {13'h0000, 8'h3C, 8'h3C};
		tab[1] = {13'h1FEF, 8'hC3, 8'hC3};
		tab[2] = {13'h1FF1, 8'hA5, 8'hA5};
		tab[3] = {13'h1FF2, 8'hD9, 8'hD9};
		tab[4] = {13'h1FF3, 8'hD9, 8'hD9};
		tab[5] = {13'h1FF4, 8'hA3, 8'hA3};
		tab[6] = {13'h1FF5, 8'hB1, 8'hB1};
		tab[7] = {13'h1FF6, 8'hFF, 8'hA0};
		tab[8] = {13'h1FF7, 8'hFE, 8'hFE};
		tab[9] = {13'h1FF8, 8'h3F, 8'h3F};
		tab[10] = {13'h1FF0, 8'hFF, 8'h90};
		tab[11] = {13'h1FFC, 8'h66, 8'h61};
		repeat (2) @(posedge core_clk_in);
		#1;
		chk(cpu_reset_n_out, 1'b0, 13'h0000);
		chk(data_oe_out, 1'b0, 13'h0000);
		rstn_in = 1'b1;
		wait_up;
		for (i = 0; i < 12; i = i + 1)
		begin
			host.wr(tab[i][28:16], tab[i][15:8]);
			host.rd(tab[i][28:16], v);
			chk(data_oe_out, 1'b1, tab[i][28:16]);
			chk(v, tab[i][7:0], tab[i][28:16]);
		end
		host.wr(13'h1FF8, 8'h80);
		for (i = 0; i < 7; i = i + 1)
			host.wr(13'h1FF9 + i, LOADED[55 - 8 * i -: 8]);
		host.wr(13'h1FF8, 8'h00);
		repeat (3 * SEC) @(posedge core_clk_in);
		for (i = 0; i < 7; i = i + 1)
		begin
			host.rd(13'h1FF9 + i, v);
			chk(v, LOADED[55 - 8 * i -: 8], 13'h1FF9 + i);
		end
		host.wr(13'h1FF9, 8'h59);
		n = 0;
		v = 8'hD9;
		while (v !== 8'h00 && n < 2 * SEC)
		begin
			host.rd(13'h1FF9, v);
			n = n + 1;
		end
		chk(v, 8'h00, 13'h1FF9);
		if (v !== 8'h00)
			print_verdict;
		for (i = 0; i < 7; i = i + 1)
		begin
			host.rd(13'h1FF9 + i, v);
			chk(v, ROLLED[55 - 8 * i -: 8], 13'h1FF9 + i);
		end
		host.wr(13'h1FF8, 8'h40);
		host.rd(13'h1FF9, s0);
		repeat (2 * SEC) @(posedge core_clk_in);
		host.rd(13'h1FF9, v);
		chk(v, s0, 13'h1FF9);
		host.wr(13'h1FF8, 8'h00);
		host.rd(13'h1FF9, v);
		chk(v == s0, 1'b0, 13'h1FF9);
		host.wr(13'h1FF8, 8'h40);
		power_good_in = 1'b0;
		host.wr(13'h1FF1, 8'h11);
		host.rd(13'h1FF1, v);
		chk(data_oe_out, 1'b0, 13'h1FF1);
		power_good_in = 1'b1;
		chk(cpu_reset_n_out, 1'b0, 13'h0000);
		wait_up;
		host.rd(13'h1FF1, v);
		chk(v, 8'hA5, 13'h1FF1);
		host.rd(13'h1FF8, v);
		chk(v, 8'h00, 13'h1FF8);
		print_verdict;
	end
endmodule
